// ===== verilog/ccg_codec_clock_gen.sv
// codec clock gating, gpio clock divider and slow timeout clock with apb regs
`default_nettype none
`include "ccg_params.svh"
// Operation
// - converter clock runs only when its gate and the core gate are set
// - adc oversample bit set gives 128x, cleared gives 64x; resets to 1
// - gpio clock runs only while its gate bit 3 is set
// - gpio divider codes 0..8 give 1,2,3,4,5.5,6,8,12,16; rest reserved
// - gpio clock reaches the pin only when pin routing selects it
// - slow clock from 256kHz runs only while its gate bit 0 is set
// - bit 12 cleared halves the slow clock, set leaves it
// - bit 14 set divides the slow clock by sixteen
// - bit 13 multiplies slow clock by four; rates 1000 Hz to 7.8125 Hz
// - core clock comes from the master clock input at high rates
// - sample rate code 101 denotes the 44.1/48 kHz family
module ccg_codec_clock_gen #(
    parameter int DIV256 = `CCG_CORE_HZ / `CCG_SLOW_HZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire ccg_pkg::ccg_addr_t paddr,
    input wire ccg_pkg::ccg_word_t pwdata,
    output ccg_pkg::ccg_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gpio_pin_route,
    output logic conv_clock_en,
    output logic adc_osr_high,
    output logic gpio_clock_out,
    output logic gpio_clock_tick,
    output logic gpio_pin_out,
    output logic slow_timeout_clock,
    output logic slow_timeout_tick,
    output logic fs_family_48,
    output logic [3:0] core_to_fs_ratio
);
    import ccg_pkg::*;

    if (DIV256 < 2 || DIV256 > 65535) begin : g_bad_div
        $error("DIV256 out of range");
    end

    localparam logic [15:0] DIV_M1 = 16'(DIV256 - 1);

    ccg_reg_t analog_adc_ctrl0, clock_divider_ctrl0, sample_rate_ctrl;
    ccg_reg_t clock_enable_ctrl, audio_iface_ctrl2;
    logic [9:0] widx;
    logic hit, wr_en, core_on, gpio_run_req, gact, gphase;
    logic [5:0] p_cfg, gp, gcnt, glen, next_gp, next_gcnt;
    logic next_gact, next_gphase, next_gtick;
    logic [15:0] d256;
    logic tick256, slow_run, sact;
    logic [14:0] scnt, shalf;

    // twice the gpio divide ratio; zero marks a reserved code
    function automatic logic [5:0] gdiv_x2(input logic [3:0] code);
        case (code)
            CCG_GDIV_1: return 6'h02;
            CCG_GDIV_2: return 6'h04;
            CCG_GDIV_3: return 6'h06;
            CCG_GDIV_4: return 6'h08;
            CCG_GDIV_5P5: return 6'h0b;
            CCG_GDIV_6: return 6'h0c;
            CCG_GDIV_8: return 6'h10;
            CCG_GDIV_12: return 6'h18;
            CCG_GDIV_16: return 6'h20;
            default: return 6'h00;
        endcase
    endfunction

    // length of one gpio period; odd doubled ratios (5.5) alternate by phase
    function automatic logic [5:0] gper(input logic [5:0] p,
                                        input logic ph);
        return {1'b0, p[5:1]} + {5'h00, p[0] & ph};
    endfunction

    // slow clock half period in 256kHz ticks
    function automatic logic [14:0] slow_half(input logic half,
                                              input logic x4,
                                              input logic d16);
        logic [14:0] v;
        v = `CCG_SLOW_HALF_BASE;
        if (!half) v = v << 1;
        if (d16) v = v << 4;
        if (x4) v = v >> 2;
        return v;
    endfunction

    // word index is mapped
    function automatic logic map_hit(input logic [9:0] i);
        return i == `CCG_IDX_ADC0 || i == `CCG_IDX_DIV0 ||
            i == `CCG_IDX_RATE || i == `CCG_IDX_ENA ||
            i == `CCG_IDX_AIF2 || i == `CCG_IDX_STAT;
    endfunction

    // apb decode; zero wait state, error on unmapped or unaligned
    assign widx = paddr[11:2];
    assign hit = map_hit(widx) && paddr[1:0] == 2'h0;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit;
    assign wr_en = psel && penable && pwrite && hit;

    // register writes take effect at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_adc_ctrl0 <= `CCG_RST_ADC0;
            clock_divider_ctrl0 <= `CCG_RST_DIV0;
            sample_rate_ctrl <= `CCG_RST_RATE;
            clock_enable_ctrl <= `CCG_RST_ENA;
            audio_iface_ctrl2 <= `CCG_RST_AIF2;
        end else if (wr_en) begin
            case (widx)
                `CCG_IDX_ADC0: analog_adc_ctrl0 <= pwdata[15:0];
                `CCG_IDX_DIV0: clock_divider_ctrl0 <= pwdata[15:0];
                `CCG_IDX_RATE: sample_rate_ctrl <= pwdata[15:0];
                `CCG_IDX_ENA: clock_enable_ctrl <= pwdata[15:0];
                `CCG_IDX_AIF2: audio_iface_ctrl2 <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (widx)
                `CCG_IDX_ADC0: prdata <= {16'h0000, analog_adc_ctrl0};
                `CCG_IDX_DIV0: prdata <= {16'h0000, clock_divider_ctrl0};
                `CCG_IDX_RATE: prdata <= {16'h0000, sample_rate_ctrl};
                `CCG_IDX_ENA: prdata <= {16'h0000, clock_enable_ctrl};
                `CCG_IDX_AIF2: prdata <= {16'h0000, audio_iface_ctrl2};
                `CCG_IDX_STAT: prdata <= {26'h0000000, p_cfg == 6'h00,
                    fs_family_48, slow_timeout_clock, gact,
                    conv_clock_en, core_on};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // core clock is pclk itself, i.e. the master clock path
    assign core_on = clock_enable_ctrl[`CCG_B_CORE_EN];
    assign adc_osr_high = analog_adc_ctrl0[`CCG_B_ADC_OSR];
    assign fs_family_48 =
        sample_rate_ctrl[`CCG_F_FS_LO +: 3] == `CCG_FS_48K;
    assign core_to_fs_ratio = sample_rate_ctrl[`CCG_F_RATIO_LO +: 4];

    // converter clock gate needs both enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_clock_en <= 1'b0;
        end else begin
            conv_clock_en <= core_on &&
                clock_enable_ctrl[`CCG_B_CONV_EN];
        end
    end

    // gpio divider: config latched at period start, stops at period end
    assign p_cfg = gdiv_x2(audio_iface_ctrl2[`CCG_F_GDIV_LO +: 4]);
    assign gpio_run_req = core_on && clock_enable_ctrl[`CCG_B_GPIO_EN] &&
        p_cfg != 6'h00;
    assign glen = gper(gp, gphase);

    always_comb begin
        next_gact = gact;
        next_gp = gp;
        next_gcnt = gcnt + 6'h01;
        next_gphase = gphase;
        next_gtick = 1'b0;
        if (!gact) begin
            next_gcnt = 6'h00;
            if (gpio_run_req) begin
                next_gact = 1'b1;
                next_gp = p_cfg;
                next_gphase = 1'b0;
            end
        end else if (gcnt == glen - 6'h01) begin
            next_gtick = 1'b1;
            next_gcnt = 6'h00;
            next_gphase = !gphase;
            if (!gpio_run_req) begin
                next_gact = 1'b0;
            end else if (p_cfg != gp) begin
                next_gp = p_cfg;
                next_gphase = 1'b0;
            end
        end
    end

    // gpio clock state and registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gact <= 1'b0;
            gp <= 6'h00;
            gcnt <= 6'h00;
            gphase <= 1'b0;
            gpio_clock_tick <= 1'b0;
            gpio_clock_out <= 1'b0;
            gpio_pin_out <= 1'b0;
        end else begin
            gact <= next_gact;
            gp <= next_gp;
            gcnt <= next_gcnt;
            gphase <= next_gphase;
            gpio_clock_tick <= next_gtick;
            gpio_clock_out <= next_gact && next_gcnt <
                ((gper(next_gp, next_gphase) + 6'h01) >> 1);
            gpio_pin_out <= next_gact && gpio_pin_route && next_gcnt <
                ((gper(next_gp, next_gphase) + 6'h01) >> 1);
        end
    end

    // 256kHz tick from the core clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d256 <= 16'h0000;
        end else if (!core_on || d256 == DIV_M1) begin
            d256 <= 16'h0000;
        end else begin
            d256 <= d256 + 16'h0001;
        end
    end
    assign tick256 = core_on && d256 == DIV_M1;

    // slow clock: toggles every half period, stops after a high half
    assign slow_run = core_on && clock_enable_ctrl[`CCG_B_SLOW_EN];
    assign shalf = slow_half(clock_enable_ctrl[`CCG_B_HALF],
        clock_divider_ctrl0[`CCG_B_X4],
        clock_divider_ctrl0[`CCG_B_DIV16]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sact <= 1'b0;
            scnt <= 15'h0000;
            slow_timeout_clock <= 1'b0;
            slow_timeout_tick <= 1'b0;
        end else begin
            slow_timeout_tick <= 1'b0;
            if (!sact) begin
                scnt <= 15'h0000;
                if (slow_run && tick256) begin
                    sact <= 1'b1;
                    slow_timeout_clock <= 1'b1;
                    slow_timeout_tick <= 1'b1;
                end
            end else if (!slow_run && !slow_timeout_clock) begin
                sact <= 1'b0;
            end else if (tick256) begin
                if (scnt >= shalf - 15'h0001) begin
                    scnt <= 15'h0000;
                    slow_timeout_clock <= !slow_timeout_clock;
                    slow_timeout_tick <= !slow_timeout_clock && slow_run;
                    if (slow_timeout_clock && !slow_run) begin
                        sact <= 1'b0;
                    end
                end else begin
                    scnt <= scnt + 15'h0001;
                end
            end
        end
    end

    // helpers that only the checks read: period gaps
    logic [7:0] ggap, glast;
    logic [1:0] gseen;
    logic [25:0] sgap;
    logic sseen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ggap <= 8'h00;
            glast <= 8'h00;
            gseen <= 2'h0;
            sgap <= 26'h0000000;
            sseen <= 1'b0;
        end else begin
            ggap <= gpio_clock_tick ? 8'h01 : ggap + 8'h01;
            if (gpio_clock_tick) glast <= ggap;
            if (!gact || (wr_en && widx == `CCG_IDX_AIF2)) gseen <= 2'h0;
            else if (gpio_clock_tick && gseen != 2'h3) gseen <= gseen + 2'h1;
            sgap <= slow_timeout_tick ? 26'h0000001 : sgap + 26'h0000001;
            if (!slow_run || (wr_en && (widx == `CCG_IDX_ENA ||
                widx == `CCG_IDX_DIV0))) sseen <= 1'b0;
            else if (slow_timeout_tick) sseen <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_adc_write;
        psel && penable && pwrite && paddr == {`CCG_IDX_ADC0, 2'h0};
    endsequence
    sequence s_rate_write;
        psel && penable && pwrite && paddr == {`CCG_IDX_RATE, 2'h0};
    endsequence

    a_conv_gate_follow: assert property (
        ##1 conv_clock_en == $past(clock_enable_ctrl[`CCG_B_CORE_EN] &&
            clock_enable_ctrl[`CCG_B_CONV_EN]))
        else $error("converter gate wrong");
    a_adc_osr_write: assert property (
        s_adc_write |=> adc_osr_high == $past(pwdata[0]))
        else $error("adc oversample bit not taken");
    a_gpio_stop_low: assert property (
        !gpio_run_req [*2] |-> ##[0:16] !gact && !gpio_clock_out)
        else $error("gpio clock did not stop low");
    a_gpio_gap_len: assert property (
        gpio_clock_tick && gseen == 2'h3 |->
            ggap == {2'h0, gp[5:1]} || ggap == {2'h0, gp[5:1]} + 8'h01)
        else $error("gpio period wrong");
    a_gpio_half_pair: assert property (
        gpio_clock_tick && gseen == 2'h3 && gp == 6'h0b |->
            ggap + glast == 8'h0b)
        else $error("5.5 divide pair wrong");
    a_pin_route_gate: assert property (
        gpio_pin_out |-> gpio_clock_out && $past(gpio_pin_route))
        else $error("gpio pin driven without routing");
    a_slow_off_low: assert property (
        !slow_run && !slow_timeout_clock |=> !slow_timeout_clock)
        else $error("slow clock restarted while gated");
    a_slow_period: assert property (
        slow_timeout_tick && sseen && $stable(shalf) |->
            sgap == 26'({shalf, 1'b0}) * 26'(DIV256))
        else $error("slow clock period wrong");
    a_fs_family: assert property (
        s_rate_write |=> fs_family_48 == ($past(pwdata[2:0]) == 3'h5))
        else $error("rate family flag wrong");
endmodule
`default_nettype wire

// ===== verilog/ccg_params.svh
// register indices, field positions, reset values and timing of the clock block
`ifndef CCG_PARAMS_SVH
`define CCG_PARAMS_SVH
`define CCG_IDX_ADC0 10'h00a
`define CCG_IDX_DIV0 10'h014
`define CCG_IDX_RATE 10'h015
`define CCG_IDX_ENA 10'h016
`define CCG_IDX_AIF2 10'h01a
`define CCG_IDX_STAT 10'h030
`define CCG_RST_ADC0 16'h0001
`define CCG_RST_DIV0 16'h0000
`define CCG_RST_RATE 16'h0c05
`define CCG_RST_ENA 16'h0000
`define CCG_RST_AIF2 16'h0000
`define CCG_B_ADC_OSR 0
`define CCG_B_DIV16 14
`define CCG_B_X4 13
`define CCG_B_HALF 12
`define CCG_B_GPIO_EN 3
`define CCG_B_CORE_EN 2
`define CCG_B_CONV_EN 1
`define CCG_B_SLOW_EN 0
`define CCG_F_GDIV_LO 8
`define CCG_F_RATIO_LO 10
`define CCG_F_FS_LO 0
`define CCG_FS_48K 3'h5
`define CCG_CORE_HZ 125000000
`define CCG_SLOW_HZ 256000
`define CCG_SLOW_HALF_BASE 15'h0200
`endif

// ===== verilog/ccg_pkg.sv
// types shared by the codec clock generation block
`default_nettype none
package ccg_pkg;
    typedef logic [11:0] ccg_addr_t;
    typedef logic [31:0] ccg_word_t;
    typedef logic [15:0] ccg_reg_t;
    // gpio clock divider codes
    typedef enum logic [3:0] {
        CCG_GDIV_1 = 4'h0, CCG_GDIV_2 = 4'h1, CCG_GDIV_3 = 4'h2,
        CCG_GDIV_4 = 4'h3, CCG_GDIV_5P5 = 4'h4, CCG_GDIV_6 = 4'h5,
        CCG_GDIV_8 = 4'h6, CCG_GDIV_12 = 4'h7, CCG_GDIV_16 = 4'h8
    } ccg_gdiv_e;
endpackage
`default_nettype wire

// ===== dv/tb.sv
// self-checking testbench for the codec clock generation block
`default_nettype none
`include "ccg_params.svh"
module tb import ccg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 2;
    localparam logic [11:0] A_ADC0 = {`CCG_IDX_ADC0, 2'b00};
    localparam logic [11:0] A_DIV0 = {`CCG_IDX_DIV0, 2'b00};
    localparam logic [11:0] A_RATE = {`CCG_IDX_RATE, 2'b00};
    localparam logic [11:0] A_ENA = {`CCG_IDX_ENA, 2'b00};
    localparam logic [11:0] A_AIF2 = {`CCG_IDX_AIF2, 2'b00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    ccg_addr_t paddr = '0;
    ccg_word_t pwdata = '0;
    ccg_word_t prdata;
    logic pready;
    logic pslverr;
    logic gpio_pin_route = 1'b0;
    logic conv_clock_en;
    logic adc_osr_high;
    logic gpio_clock_out;
    logic gpio_clock_tick;
    logic gpio_pin_out;
    logic slow_timeout_clock;
    logic slow_timeout_tick;
    logic fs_family_48;
    logic [3:0] core_to_fs_ratio;
    int err_total = 0;
    int n_checks = 0;
    int gsum[9] = '{2, 4, 6, 8, 11, 12, 16, 24, 32};
    logic [2:0] scfg[4] = '{3'b100, 3'b111, 3'b010, 3'b110};

    // 125 MHz clock
    always #4 pclk = ~pclk;

    ccg_codec_clock_gen #(.DIV256(DIV)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .gpio_pin_route(gpio_pin_route), .conv_clock_en(conv_clock_en),
        .adc_osr_high(adc_osr_high), .gpio_clock_out(gpio_clock_out),
        .gpio_clock_tick(gpio_clock_tick), .gpio_pin_out(gpio_pin_out),
        .slow_timeout_clock(slow_timeout_clock),
        .slow_timeout_tick(slow_timeout_tick),
        .fs_family_48(fs_family_48), .core_to_fs_ratio(core_to_fs_ratio)
    );

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one apb transfer, setup then access until pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge pclk);
        end
        check("pready", n < 16, 1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
        check("write error", e, 0);
        // let the written register settle before anyone looks
        @(posedge pclk);
    endtask

    task automatic rdc(input string what, input logic [11:0] a,
                       input logic [31:0] exp);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 0, rd, e);
        check(what, rd, exp);
    endtask

    // cycles until the next gpio or slow tick
    task automatic wait_tick(input logic slow, input int lim, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((slow ? slow_timeout_tick : gpio_clock_tick) !== 1'b1
                   && n < lim);
    endtask

    // count cycles with a chosen output high
    task automatic cnt(input int sel, input int cyc, output int h);
        h = 0;
        repeat (cyc) begin
            @(posedge pclk);
            case (sel)
                0: h += (gpio_pin_out === 1'b1);
                1: h += (gpio_clock_out === 1'b1);
                2: h += (gpio_clock_tick === 1'b1);
                default: h += (slow_timeout_clock === 1'b1);
            endcase
        end
    endtask

    // main sequence
    initial begin
        int g1, g2, h, ex;
        logic [31:0] v;
        logic e;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("adc0 reset", A_ADC0, `CCG_RST_ADC0);
        rdc("rate reset", A_RATE, `CCG_RST_RATE);
        rdc("ena reset", A_ENA, 0);
        rdc("aif2 reset", A_AIF2, 0);
        rdc("div0 reset", A_DIV0, 0);
        check("osr reset", adc_osr_high, 1);
        check("family reset", fs_family_48, 1);
        check("ratio reset", core_to_fs_ratio, 4'h3);
        apb(1'b0, 12'h100, 0, v, e);
        check("unmapped err", e, 1);
        check("unmapped data", v, 0);
        apb(1'b0, 12'h029, 0, v, e);
        check("unaligned err", e, 1);
        wr(A_RATE, 32'h0c04);
        check("family off", fs_family_48, 0);
        wr(A_RATE, 32'h0c05);
        check("family on", fs_family_48, 1);
        wr(A_RATE, 32'h0405);
        check("ratio high rate", core_to_fs_ratio, 4'h1);
        check("family high rate", fs_family_48, 1);
        wr(A_ADC0, 0);
        rdc("adc0 low", A_ADC0, 0);
        check("osr low", adc_osr_high, 0);
        wr(A_ADC0, 1);
        check("osr high", adc_osr_high, 1);
        wr(A_ENA, 32'h0002);
        repeat (3) @(posedge pclk);
        check("conv no core", conv_clock_en, 0);
        wr(A_ENA, 32'h0006);
        repeat (3) @(posedge pclk);
        check("conv on", conv_clock_en, 1);
        rdc("status", 12'h0c0, 32'h0000_0013);
        wr(A_ENA, 32'h000c);
        repeat (3) @(posedge pclk);
        check("conv off", conv_clock_en, 0);
        gpio_pin_route <= 1'b1;
        for (int c = 0; c < 9; c++) begin
            wr(A_AIF2, c << 8);
            rdc("aif2 code", A_AIF2, c << 8);
            wait_tick(1'b0, 80, g1);
            wait_tick(1'b0, 80, g1);
            wait_tick(1'b0, 80, g1);
            wait_tick(1'b0, 80, g2);
            check("gpio two periods", g1 + g2, gsum[c]);
            if (c == 4) begin
                check("gpio alternates", g1 == g2, 0);
            end
        end
        wr(A_AIF2, 32'h0300);
        cnt(0, 32, h);
        check("pin routed", h > 0, 1);
        gpio_pin_route <= 1'b0;
        cnt(0, 4, h);
        cnt(0, 32, h);
        check("pin unrouted", h, 0);
        wr(A_AIF2, 32'h0900);
        cnt(2, 40, h);
        cnt(2, 40, h);
        check("reserved code", h, 0);
        wr(A_AIF2, 32'h0300);
        wr(A_ENA, 32'h0004);
        cnt(1, 20, h);
        cnt(1, 40, h);
        check("gpio gated low", h, 0);
        for (int k = 0; k < 4; k++) begin
            wr(A_DIV0, {scfg[k][0], scfg[k][1], 13'h0000});
            wr(A_ENA, {scfg[k][2], 12'h005});
            ex = 2 * 512 * (scfg[k][2] ? 1 : 2) * (scfg[k][0] ? 16 : 1)
                 / (scfg[k][1] ? 4 : 1) * DIV;
            wait_tick(1'b1, 3 * ex + 100, g1);
            wait_tick(1'b1, 3 * ex + 100, g1);
            wait_tick(1'b1, 3 * ex + 100, g1);
            check("slow spacing", g1, ex);
        end
        wr(A_ENA, 32'h1004);
        cnt(3, 600, h);
        cnt(3, 200, h);
        check("slow gated low", h, 0);
        complete_run();
    end

    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
